// ==== rtl/pulse_pkg.sv ====
/*
  Shared constants for the pulse width measurer and pulse emitter:
  counting unit, timeout length, field widths and state encodings.
  Assumes a single system clock of 10 MHz; the unit is a fixed count of clocks.
*/
package pulse_pkg;

  // ---------------------------------------------------------------
  // clock and counting unit
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;    // system clock period, 10 MHz
  localparam int REF_CLK_MHZ   = 4;      // reference clock for the unit
  localparam int UNIT_TIME_NS  = 10000;  // 10 us unit at the reference clock
  // the unit is a fixed number of clocks, so it scales with the clock
  localparam int UNIT_CYCLES   = (UNIT_TIME_NS * REF_CLK_MHZ) / 1000;
  localparam int UNIT_CNT_W    = 6;
  localparam logic [UNIT_CNT_W-1:0] UNIT_LAST = UNIT_CNT_W'(UNIT_CYCLES - 1);

  // ---------------------------------------------------------------
  // widths, limits and timeout
  // ---------------------------------------------------------------
  localparam int RESULT_W      = 16;
  localparam int WAIT_W        = 17;
  localparam int TIMEOUT_UNITS = 65536;  // 0.65536 s at the reference clock
  localparam logic [RESULT_W-1:0] WIDTH_MAX  = 16'hFFFF;
  localparam logic [RESULT_W-1:0] WIDTH_ZERO = 16'h0000;
  localparam logic [RESULT_W-1:0] WIDTH_ONE  = 16'h0001;
  localparam int SYNC_STAGES   = 3;
  localparam int PIN_MEAS      = 0;      // index of the measured pin
  localparam int PIN_GEN       = 1;      // index of the emitter pin

  // ---------------------------------------------------------------
  // state encodings, gray from M_IDLE to M_ARM to M_TIME
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    M_IDLE = 2'h0,
    M_ARM  = 2'h1,
    M_TIME = 2'h3
  } meas_state_e;

  typedef enum logic [0:0] {
    G_IDLE  = 1'h0,
    G_PULSE = 1'h1
  } gen_state_e;

endpackage

// ==== rtl/unit_tick.sv ====
/*
  Unit tick generator: one tick every UNIT_CYCLES clocks while run is high.
  Assumes clr and run come from logic on clk_sys; tick is combinational.
*/
`timescale 1ns/10ps
`default_nettype none

module unit_tick
  import pulse_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic run,
  input  wire logic clr,
  output logic      tick
);

  logic [UNIT_CNT_W-1:0] cnt_reg;
  logic [UNIT_CNT_W-1:0] cnt_next;

  // ---------------------------------------------------------------
  // unit counter
  // ---------------------------------------------------------------
  // tick on the last clock of each unit
  assign tick = run && !clr && (cnt_reg == UNIT_LAST);

  // next count, restarted by clr
  always_comb begin
    cnt_next = cnt_reg;
    if (clr || !run || tick) begin
      cnt_next = '0;
    end else begin
      cnt_next = cnt_reg + UNIT_CNT_W'(1);
    end
  end

  // register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_unit_len;
    @(posedge clk_sys) disable iff (!rst_n)
      (tick && run) |-> ($past(cnt_reg) == UNIT_LAST - UNIT_CNT_W'(1)) || $past(clr);
  endproperty
  a_unit_len: assert property (p_unit_len) else $error("unit tick out of step");

endmodule
`default_nettype wire

// ==== rtl/pulse_width_measure_and_emit.sv ====
/*
  Pulse width measurement on one input pin and timed pulse emission on one
  two-way pin, both counting in units of UNIT_CYCLES system clocks.
  Assumes pins are asynchronous to clk_sys; commands come from clk_sys logic.
*/
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - edge select one: timing starts on a low to high transition only
// - edge select zero: timing starts on a high to low transition only
// - width counts in 10 us units at 4 MHz, i.e. fixed clocks per unit
// - result is a 16-bit word, valid widths one to 65535 units
// - no pulse completed within 65536 units: stop and report zero
// - unit and timeout shrink in proportion as the clock speeds up
// - emitted pulse lasts programmed count, 0 to 65535, times the unit
// - emitted pulse is the opposite of the pin's current level
// - emitter turns the pin to output itself; user should preset output
module pulse_width_measure_and_emit
  import pulse_pkg::*;
#(
  parameter int TIMEOUT_LEN = TIMEOUT_UNITS
)
(
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic                meas_start,
  input  wire logic                meas_edge_sel,
  input  wire logic                meas_pin_in,
  output logic                     meas_busy,
  output logic                     meas_done,
  output logic                     meas_timeout,
  output logic [RESULT_W-1:0]      meas_result,
  input  wire logic                gen_start,
  input  wire logic [RESULT_W-1:0] gen_count,
  input  wire logic                gen_pin_in,
  output logic                     gen_pin_out,
  output logic                     gen_pin_oe,
  output logic                     gen_busy,
  output logic                     gen_done
);

  // ---------------------------------------------------------------
  // pin synchronisers and level filters
  // ---------------------------------------------------------------
  logic [1:0] pin_raw;
  logic [1:0] lvl;
  logic [1:0] agree;

  assign pin_raw[PIN_MEAS] = meas_pin_in;
  assign pin_raw[PIN_GEN]  = gen_pin_in;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      logic [SYNC_STAGES-1:0] sync_reg;
      logic [SYNC_STAGES-1:0] sync_next;
      logic                   lvl_reg;
      logic                   lvl_next;
      // shift in; the level moves only when stages two and three agree
      always_comb begin
        sync_next = {sync_reg[SYNC_STAGES-2:0], pin_raw[gi]};
        lvl_next  = lvl_reg;
        if (sync_reg[1] == sync_reg[2]) begin
          lvl_next = sync_reg[2];
        end
      end
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          sync_reg <= '0;
          lvl_reg  <= 1'b0;
        end else begin
          sync_reg <= sync_next;
          lvl_reg  <= lvl_next;
        end
      end
      assign lvl[gi]   = lvl_reg;
      assign agree[gi] = (sync_reg[1] == sync_reg[2]);
    end
  endgenerate

  // edges on the measured pin, seen one clock before the level moves
  logic rise_w;
  logic fall_w;
  assign rise_w = agree[PIN_MEAS] && g_pin[PIN_MEAS].sync_reg[2] && !lvl[PIN_MEAS];
  assign fall_w = agree[PIN_MEAS] && !g_pin[PIN_MEAS].sync_reg[2] && lvl[PIN_MEAS];

  // ---------------------------------------------------------------
  // measurement
  // ---------------------------------------------------------------
  meas_state_e         m_st_reg, m_st_next;
  logic                pol_reg, pol_next;
  logic [WAIT_W-1:0]   wait_reg, wait_next;
  logic [RESULT_W-1:0] width_reg, width_next;
  logic [RESULT_W-1:0] mres_reg, mres_next;
  logic                mbusy_reg, mbusy_next;
  logic                mdone_reg, mdone_next;
  logic                mto_reg, mto_next;
  logic                m_tick;
  logic                m_clr;
  logic                start_edge;
  logic                stop_edge;

  assign start_edge = pol_reg ? rise_w : fall_w;
  assign stop_edge  = pol_reg ? fall_w : rise_w;
  assign m_clr      = (m_st_reg == M_IDLE) || (m_st_reg == M_ARM && start_edge);

  unit_tick u_meas_tick (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .run     (m_st_reg != M_IDLE),
    .clr     (m_clr),
    .tick    (m_tick)
  );

  // next state of the measurement
  always_comb begin
    m_st_next  = m_st_reg;
    pol_next   = pol_reg;
    wait_next  = wait_reg;
    width_next = width_reg;
    mres_next  = mres_reg;
    mdone_next = 1'b0;
    mto_next   = mto_reg;
    case (m_st_reg)
      M_IDLE: begin
        if (meas_start) begin
          m_st_next = M_ARM;
          pol_next  = meas_edge_sel;
          wait_next = '0;
        end
      end
      M_ARM: begin
        if (start_edge) begin
          m_st_next  = M_TIME;
          width_next = WIDTH_ONE;
        end else if (m_tick) begin
          wait_next = wait_reg + WAIT_W'(1);
          if (wait_reg == WAIT_W'(TIMEOUT_LEN - 1)) begin
            m_st_next  = M_IDLE;
            mres_next  = WIDTH_ZERO;
            mto_next   = 1'b1;
            mdone_next = 1'b1;
          end
        end
      end
      M_TIME: begin
        if (stop_edge) begin
          m_st_next  = M_IDLE;
          mres_next  = width_reg;
          mto_next   = 1'b0;
          mdone_next = 1'b1;
        end else if (m_tick) begin
          if (width_reg == WIDTH_MAX) begin
            m_st_next  = M_IDLE;
            mres_next  = WIDTH_ZERO;
            mto_next   = 1'b1;
            mdone_next = 1'b1;
          end else begin
            width_next = width_reg + WIDTH_ONE;
          end
        end
      end
      default: begin
        m_st_next = M_IDLE;
      end
    endcase
    mbusy_next = (m_st_next != M_IDLE);
  end

  // measurement registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      m_st_reg  <= M_IDLE;
      pol_reg   <= 1'b0;
      wait_reg  <= '0;
      width_reg <= '0;
      mres_reg  <= '0;
      mbusy_reg <= 1'b0;
      mdone_reg <= 1'b0;
      mto_reg   <= 1'b0;
    end else begin
      m_st_reg  <= m_st_next;
      pol_reg   <= pol_next;
      wait_reg  <= wait_next;
      width_reg <= width_next;
      mres_reg  <= mres_next;
      mbusy_reg <= mbusy_next;
      mdone_reg <= mdone_next;
      mto_reg   <= mto_next;
    end
  end

  assign meas_busy    = mbusy_reg;
  assign meas_done    = mdone_reg;
  assign meas_timeout = mto_reg;
  assign meas_result  = mres_reg;

  // ---------------------------------------------------------------
  // pulse emitter
  // ---------------------------------------------------------------
  gen_state_e          g_st_reg, g_st_next;
  logic [RESULT_W-1:0] left_reg, left_next;
  logic                base_reg, base_next;
  logic                out_reg, out_next;
  logic                oe_reg, oe_next;
  logic                gdone_reg, gdone_next;
  logic                g_tick;
  logic                g_go;
  logic                level_now;

  // present pin level: own drive if already output, else the pin
  assign level_now = oe_reg ? out_reg : lvl[PIN_GEN];
  assign g_go      = (g_st_reg == G_IDLE) && gen_start;

  unit_tick u_gen_tick (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .run     (g_st_reg == G_PULSE),
    .clr     (g_go),
    .tick    (g_tick)
  );

  // next state of the emitter
  always_comb begin
    g_st_next  = g_st_reg;
    left_next  = left_reg;
    base_next  = base_reg;
    out_next   = out_reg;
    oe_next    = oe_reg;
    gdone_next = 1'b0;
    case (g_st_reg)
      G_IDLE: begin
        if (gen_start) begin
          oe_next   = 1'b1;
          base_next = level_now;
          left_next = gen_count;
          if (gen_count == WIDTH_ZERO) begin
            out_next   = level_now;
            gdone_next = 1'b1;
          end else begin
            out_next  = !level_now;
            g_st_next = G_PULSE;
          end
        end
      end
      G_PULSE: begin
        if (g_tick) begin
          left_next = left_reg - WIDTH_ONE;
          if (left_reg == WIDTH_ONE) begin
            out_next   = base_reg;
            gdone_next = 1'b1;
            g_st_next  = G_IDLE;
          end
        end
      end
      default: begin
        g_st_next = G_IDLE;
      end
    endcase
  end

  // emitter registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      g_st_reg  <= G_IDLE;
      left_reg  <= '0;
      base_reg  <= 1'b0;
      out_reg   <= 1'b0;
      oe_reg    <= 1'b0;
      gdone_reg <= 1'b0;
    end else begin
      g_st_reg  <= g_st_next;
      left_reg  <= left_next;
      base_reg  <= base_next;
      out_reg   <= out_next;
      oe_reg    <= oe_next;
      gdone_reg <= gdone_next;
    end
  end

  assign gen_pin_out = out_reg;
  assign gen_pin_oe  = oe_reg;
  assign gen_busy    = (g_st_reg == G_PULSE);
  assign gen_done    = gdone_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_rise_start;
    @(posedge clk_sys) disable iff (!rst_n)
      (m_st_reg == M_ARM && pol_reg && m_st_next == M_TIME) |=> lvl[PIN_MEAS];
  endproperty
  a_rise_start: assert property (p_rise_start) else $error("rise start missed");

  property p_fall_start;
    @(posedge clk_sys) disable iff (!rst_n)
      (m_st_reg == M_ARM && !pol_reg && m_st_next == M_TIME) |=> !lvl[PIN_MEAS];
  endproperty
  a_fall_start: assert property (p_fall_start) else $error("fall start missed");

  property p_unit_one;
    @(posedge clk_sys) disable iff (!rst_n)
      (g_go && gen_count == WIDTH_ONE) |-> ##40 gen_busy ##1 !gen_busy;
  endproperty
  a_unit_one: assert property (p_unit_one) else $error("one unit pulse wrong");

  property p_good_result;
    @(posedge clk_sys) disable iff (!rst_n)
      (meas_done && !meas_timeout) |-> (meas_result != WIDTH_ZERO);
  endproperty
  a_good_result: assert property (p_good_result) else $error("zero good result");

  property p_timeout_zero;
    @(posedge clk_sys) disable iff (!rst_n)
      (meas_done && meas_timeout) |-> (meas_result == WIDTH_ZERO) && !meas_busy;
  endproperty
  a_timeout_zero: assert property (p_timeout_zero) else $error("timeout not zero");

  property p_wait_end;
    @(posedge clk_sys) disable iff (!rst_n)
      (m_st_reg == M_ARM && !start_edge && m_tick && wait_reg == WAIT_W'(TIMEOUT_LEN - 1))
      |=> meas_done && meas_timeout;
  endproperty
  a_wait_end: assert property (p_wait_end) else $error("wait timeout missed");

  property p_two_units;
    @(posedge clk_sys) disable iff (!rst_n)
      (g_go && gen_count == 16'h0002) |-> ##80 gen_busy ##1 (!gen_busy && gen_done);
  endproperty
  a_two_units: assert property (p_two_units) else $error("two unit pulse wrong");

  property p_invert;
    @(posedge clk_sys) disable iff (!rst_n)
      (g_go && gen_count != WIDTH_ZERO) |=> (gen_pin_out == !$past(level_now));
  endproperty
  a_invert: assert property (p_invert) else $error("pulse not inverted");

  property p_drive;
    @(posedge clk_sys) disable iff (!rst_n)
      g_go |=> gen_pin_oe;
  endproperty
  a_drive: assert property (p_drive) else $error("pin not turned output");

  property p_restore;
    @(posedge clk_sys) disable iff (!rst_n)
      $fell(gen_busy) |-> (gen_pin_out == base_reg) && gen_done;
  endproperty
  a_restore: assert property (p_restore) else $error("level not restored");

  property p_stop;
    @(posedge clk_sys) disable iff (!rst_n)
      (m_st_reg == M_TIME && stop_edge) |=> meas_done && !meas_timeout && !meas_busy;
  endproperty
  a_stop: assert property (p_stop) else $error("timing did not stop");

  c_meas_ok: cover property (@(posedge clk_sys) disable iff (!rst_n) meas_done && !meas_timeout);
  c_meas_to: cover property (@(posedge clk_sys) disable iff (!rst_n) meas_done && meas_timeout);
  c_gen_done: cover property (@(posedge clk_sys) disable iff (!rst_n) $fell(gen_busy));

endmodule
`default_nettype wire

// ==== verif/signal_rig.sv ====
/*
  Far-side model: an external signal source on the measured pin and a
  load with a pull resistor on the emitter pin.
  Assumes the bench calls set_meas just after a falling clock edge.
*/
`timescale 1ns/10ps
`default_nettype none

module signal_rig (
  input  wire logic clk_sys,
  input  wire logic gen_pin_out,
  input  wire logic gen_pin_oe,
  input  wire logic park_level,
  output logic      gen_wire,
  output var logic  meas_pin
);
  // ----------------------------------------
  // emitter pin wire
  // ----------------------------------------
  // released pin falls to the pull level, never the last driven value
  assign gen_wire = gen_pin_oe ? gen_pin_out : park_level;

  initial meas_pin = 1'b0;

  // set the source level, then hold it for n clocks
  task automatic set_meas(input logic v, input int n);
    meas_pin = v;
    repeat (n) @(negedge clk_sys);
  endtask
endmodule

`default_nettype wire

// ==== verif/pulse_width_measure_and_emit_tb.sv ====
/*
  Self-checking bench for the pulse measurer and emitter.
  Assumes a shortened wait timeout and a unit of UNIT_CYCLES clocks.
*/
`timescale 1ns/10ps
`default_nettype none

module pulse_width_measure_and_emit_tb
  import pulse_pkg::*;
;
  localparam int TMO = 8;

  logic                clk_sys;
  logic                rst_n;
  logic                meas_start;
  logic                meas_edge_sel;
  logic                meas_pin;
  logic                meas_busy;
  logic                meas_done;
  logic                meas_timeout;
  logic [RESULT_W-1:0] meas_result;
  logic                gen_start;
  logic [RESULT_W-1:0] gen_count;
  logic                gen_wire;
  logic                gen_pin_out;
  logic                gen_pin_oe;
  logic                gen_busy;
  logic                gen_done;
  logic                park_level;
  int                  err_count;
  int                  num_checks;
  int                  cycles;

  pulse_width_measure_and_emit #(.TIMEOUT_LEN(TMO)) pulse_width_measure_and_emit_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .meas_start(meas_start),
    .meas_edge_sel(meas_edge_sel), .meas_pin_in(meas_pin), .meas_busy(meas_busy),
    .meas_done(meas_done), .meas_timeout(meas_timeout), .meas_result(meas_result),
    .gen_start(gen_start), .gen_count(gen_count), .gen_pin_in(gen_wire),
    .gen_pin_out(gen_pin_out), .gen_pin_oe(gen_pin_oe), .gen_busy(gen_busy),
    .gen_done(gen_done)
  );

  signal_rig signal_rig_i (
    .clk_sys(clk_sys), .gen_pin_out(gen_pin_out), .gen_pin_oe(gen_pin_oe),
    .park_level(park_level), .gen_wire(gen_wire), .meas_pin(meas_pin)
  );

  // ----------------------------------------
  // clock and watchdog
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      close_out();
    end
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // reset with a chosen pull level on the emitter pin
  task automatic do_reset(input logic park);
    park_level = park;
    rst_n = 1'b0;
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    check(gen_pin_oe, 1'b0, "oe after reset");
    check(meas_busy, 1'b0, "busy after reset");
    repeat (5) @(negedge clk_sys);
  endtask

  // emit n units; lvl is the level before the pulse
  task automatic gen_run(input logic [RESULT_W-1:0] n, input logic lvl);
    int   c;
    logic bad;
    c = 0;
    bad = 1'b0;
    gen_count = n;
    gen_start = 1'b1;
    @(negedge clk_sys);
    gen_start = 1'b0;
    check(gen_pin_oe, 1'b1, "emitter drives pin");
    check(gen_busy, n != 16'h0000, "busy during pulse");
    while (gen_done !== 1'b1 && c < UNIT_CYCLES * n + 5) begin
      if (gen_wire !== ~lvl)
        bad = 1'b1;
      c++;
      @(negedge clk_sys);
    end
    check(gen_done, 1'b1, "emitter done");
    check(gen_busy, 1'b0, "busy over at done");
    check(c, UNIT_CYCLES * n, "pulse length");
    check(bad, 1'b0, "pulse inverted");
    check(gen_wire, lvl, "level restored");
  endtask

  // wait for a measurement to finish, bounded
  task automatic wait_meas(input int limit, output int c);
    c = 0;
    while (meas_done !== 1'b1 && c < limit) begin
      @(negedge clk_sys);
      c++;
    end
    check(meas_done, 1'b1, "measure done");
  endtask

  // wrong edge first, then start edge, hold, stop edge
  task automatic meas_run(input logic sel, input int hold);
    int c;
    signal_rig_i.set_meas(sel, 8);
    meas_edge_sel = sel;
    meas_start = 1'b1;
    @(negedge clk_sys);
    meas_start = 1'b0;
    check(meas_busy, 1'b1, "busy after start");
    signal_rig_i.set_meas(~sel, 60);
    signal_rig_i.set_meas(sel, hold);
    check(meas_busy, 1'b1, "wrong edge ignored");
    signal_rig_i.set_meas(~sel, 0);
    wait_meas(20, c);
    check(meas_result, 1 + hold / UNIT_CYCLES, "width");
    check(meas_timeout, 1'b0, "no timeout");
  endtask

  // no start edge at all
  task automatic meas_idle_timeout();
    int c;
    signal_rig_i.set_meas(1'b0, 8);
    meas_edge_sel = 1'b1;
    meas_start = 1'b1;
    @(negedge clk_sys);
    meas_start = 1'b0;
    wait_meas(TMO * UNIT_CYCLES + 60, c);
    check(c >= TMO * UNIT_CYCLES - 10, 1'b1, "timeout not early");
    check(meas_timeout, 1'b1, "timeout flag");
    check(meas_result, WIDTH_ZERO, "timeout result");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    err_count = 0;
    num_checks = 0;
    cycles = 0;
    meas_start = 1'b0;
    meas_edge_sel = 1'b0;
    gen_start = 1'b0;
    gen_count = 16'h0000;
    do_reset(1'b1);
    gen_run(16'h0001, 1'b1);
    gen_run(16'h0000, 1'b1);
    do_reset(1'b0);
    gen_run(16'h0002, 1'b0);
    gen_run(16'h0001, 1'b0);
    meas_run(1'b1, 140);
    meas_run(1'b0, 60);
    meas_run(1'b1, 10);
    meas_idle_timeout();
    close_out();
  end
endmodule

`default_nettype wire
